/* include/pew_map.svh */
// constants for the parallel eeprom page-write host controller
// assumes a 125 MHz system clock driving the controller
`ifndef PEW_MAP_SVH
`define PEW_MAP_SVH

`define PEW_CLK_MHZ 125
`define PEW_TWC_MS 10
`define PEW_TWC_CYC (`PEW_TWC_MS * 1000 * `PEW_CLK_MHZ)
`define PEW_LOAD_WIN_US 150
`define PEW_LOAD_WIN_CYC (`PEW_LOAD_WIN_US * `PEW_CLK_MHZ)
`define PEW_TWP_NS 100
`define PEW_TWP_CYC ((`PEW_TWP_NS * `PEW_CLK_MHZ + 999) / 1000)
`define PEW_TWPH_NS 50
`define PEW_TWPH_CYC ((`PEW_TWPH_NS * `PEW_CLK_MHZ + 999) / 1000)
`define PEW_TACC_NS 120
`define PEW_TACC_CYC ((`PEW_TACC_NS * `PEW_CLK_MHZ + 999) / 1000)
`define PEW_PAGE_BYTES 64
`define PEW_LOCK_A0 13'h1555
`define PEW_LOCK_A1 13'h0aaa
`define PEW_LOCK_A2 13'h1555
`define PEW_LOCK_D0 8'haa
`define PEW_LOCK_D1 8'h55
`define PEW_LOCK_D2 8'ha0

`endif

/* include/pew_pkg.sv */
// types for the parallel eeprom page-write host controller
// assumes pew_map.svh holds the numeric constants
package pew_pkg;
  typedef enum logic [1:0] {
    PEW_CMD_READ,
    PEW_CMD_WRITE,
    PEW_CMD_LOCK_WRITE
  } pew_cmd_e;
  typedef logic [12:0] pew_addr_t;
  typedef logic [7:0] pew_data_t;
endpackage

/* hdl/pew_strobe.sv */
// one bus cycle on the eeprom pins: read or write strobe
// assumes a host controller that issues one cycle at a time
`timescale 1ns/100ps
`default_nettype none
`include "pew_map.svh"
module pew_strobe #(
  parameter int TWP = `PEW_TWP_CYC,
  parameter int TWPH = `PEW_TWPH_CYC,
  parameter int TACC = `PEW_TACC_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic wr,
  input wire pew_pkg::pew_addr_t addr,
  input wire pew_pkg::pew_data_t wdata,
  input wire pew_pkg::pew_data_t din_sync,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output pew_pkg::pew_addr_t a,
  output pew_pkg::pew_data_t dout,
  output logic doe,
  output logic done,
  output pew_pkg::pew_data_t rdata
);
  import pew_pkg::*;
  initial begin
    if (TWP < 1 || TWPH < 1 || TACC < 1 || TWP > 255 || TWPH > 255 || TACC > 252)
      $error("strobe times must fit the 8-bit counter");
  end
  // -----------------------------
  // state
  // -----------------------------
  typedef enum logic [1:0] {PST_IDLE, PST_SET, PST_PULSE, PST_HOLD} pst_e;
  typedef struct packed {
    pst_e st;
    logic [7:0] cnt;
    logic wr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    pew_addr_t a;
    pew_data_t dout;
    logic doe;
    logic done;
    pew_data_t rdata;
  } pst_s;
  pst_s r, next_r;
  // read wait covers output delay plus the two sync stages on din
  localparam logic [7:0] RD_WAIT = 8'(TACC + 3);
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      PST_IDLE: begin
        if (go) begin
          next_r.st = PST_SET;
          next_r.wr = wr;
          next_r.a = addr;
          next_r.dout = wdata;
          next_r.oe_n = 1'b1;
          next_r.ce_n = 1'b0;
        end
      end
      PST_SET: begin
        // address stable one cycle before we_n falls; oe_n high for writes
        next_r.st = PST_PULSE;
        if (r.wr) begin
          next_r.we_n = 1'b0;
          next_r.doe = 1'b1;
          next_r.cnt = 8'(TWP);
        end else begin
          next_r.oe_n = 1'b0;
          next_r.cnt = RD_WAIT;
        end
      end
      PST_PULSE: begin
        if (r.cnt > 8'h01) begin
          next_r.cnt = r.cnt - 8'h01;
        end else begin
          next_r.st = PST_HOLD;
          next_r.cnt = 8'(TWPH);
          // data held through the we_n rising edge, dropped a cycle later
          next_r.we_n = 1'b1;
          next_r.oe_n = 1'b1;
          if (!r.wr) begin
            next_r.rdata = din_sync;
          end
        end
      end
      PST_HOLD: begin
        next_r.doe = 1'b0;
        next_r.ce_n = 1'b1;
        if (r.cnt > 8'h01) begin
          next_r.cnt = r.cnt - 8'h01;
        end else begin
          next_r.st = PST_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: next_r.st = PST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: PST_IDLE, cnt: 8'h00, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
             a: 13'h0000, dout: 8'h00, doe: 1'b0, done: 1'b0, rdata: 8'h00};
    end else begin
      r <= next_r;
    end
  end
  assign ce_n = r.ce_n;
  assign oe_n = r.oe_n;
  assign we_n = r.we_n;
  assign a = r.a;
  assign dout = r.dout;
  assign doe = r.doe;
  assign done = r.done;
  assign rdata = r.rdata;
endmodule
`default_nettype wire

/* hdl/pew_host.sv */
// host controller for an 8k x 8 parallel eeprom with page write and write lock
// assumes the eeprom pins attach directly; data bus is split into in, out, enable
//
// Notes on behaviour
// - write is we pulse with ce low, oe high
// - page write loads up to 64 bytes
// - next byte within 150 us or programming starts
// - same page bits 6-12 across one load
// - three-byte sequence enables lock after cycle
// - locked writes need three-byte prefix first
// - command sequences obey byte load window
`timescale 1ns/100ps
`default_nettype none
`include "pew_map.svh"
module pew_host #(
  parameter int TWC = `PEW_TWC_CYC,
  parameter int LOAD_WIN = `PEW_LOAD_WIN_CYC,
  parameter int PAGE = `PEW_PAGE_BYTES,
  parameter pew_pkg::pew_addr_t LOCK_A0 = `PEW_LOCK_A0,
  parameter pew_pkg::pew_addr_t LOCK_A1 = `PEW_LOCK_A1,
  parameter pew_pkg::pew_addr_t LOCK_A2 = `PEW_LOCK_A2,
  parameter pew_pkg::pew_data_t LOCK_D0 = `PEW_LOCK_D0,
  parameter pew_pkg::pew_data_t LOCK_D1 = `PEW_LOCK_D1,
  parameter pew_pkg::pew_data_t LOCK_D2 = `PEW_LOCK_D2
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire pew_pkg::pew_cmd_e REQ_CMD,
  input wire pew_pkg::pew_addr_t REQ_ADDR,
  input wire pew_pkg::pew_data_t REQ_DATA,
  input wire logic REQ_LAST,
  output logic REQ_READY,
  output logic RSP_VALID,
  output pew_pkg::pew_data_t RSP_DATA,
  output logic BUSY,
  output logic TIMEOUT,
  output logic EE_CE_N,
  output logic EE_OE_N,
  output logic EE_WE_N,
  output pew_pkg::pew_addr_t EE_ADDR,
  input wire pew_pkg::pew_data_t EE_DQ_IN,
  output pew_pkg::pew_data_t EE_DQ_OUT,
  output logic EE_DQ_OE
);
  import pew_pkg::*;
  initial begin
    if (PAGE < 1 || PAGE > 64) $error("page size must be 1 to 64");
    if (LOAD_WIN < 64 || TWC <= LOAD_WIN) $error("timing counts out of range");
  end
  // -----------------------------
  // pin input sync
  // -----------------------------
  pew_data_t dq_s1, dq_s2;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= EE_DQ_IN;
      dq_s2 <= dq_s1;
    end
  end
  // -----------------------------
  // state
  // -----------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_PREFIX, PH_CYCLE, PH_LOAD, PH_POLL, PH_POLLWAIT
  } pew_ph_e;
  typedef struct packed {
    pew_ph_e ph;
    logic [1:0] pre_idx;
    logic [31:0] win;
    logic [31:0] twc;
    logic go;
    logic wr;
    pew_addr_t addr;
    pew_data_t data;
    pew_data_t last_data;
    logic [6:0] page;
    logic is_last;
    logic poll_rd;
    logic ready;
    logic rsp_valid;
    pew_data_t rsp_data;
    logic busy;
    logic timeout;
  } pew_host_s;
  pew_host_s r, next_r;
  logic st_done;
  pew_data_t st_rdata;
  function automatic pew_addr_t pre_addr(input logic [1:0] i);
    pre_addr = (i == 2'd0) ? LOCK_A0 : (i == 2'd1) ? LOCK_A1 : LOCK_A2;
  endfunction
  function automatic pew_data_t pre_data(input logic [1:0] i);
    pre_data = (i == 2'd0) ? LOCK_D0 : (i == 2'd1) ? LOCK_D1 : LOCK_D2;
  endfunction
  always_comb begin
    next_r = r;
    next_r.go = 1'b0;
    next_r.ready = 1'b0;
    next_r.rsp_valid = 1'b0;
    next_r.timeout = 1'b0;
    case (r.ph)
      PH_IDLE: begin
        next_r.ready = 1'b1;
        if (r.ready && REQ_VALID) begin
          next_r.ready = 1'b0;
          next_r.addr = REQ_ADDR;
          next_r.data = REQ_DATA;
          next_r.is_last = REQ_LAST;
          next_r.page = REQ_ADDR[12:6];
          next_r.pre_idx = 2'd0;
          next_r.win = 32'(LOAD_WIN);
          if (REQ_CMD == PEW_CMD_READ) begin
            next_r.wr = 1'b0;
            next_r.is_last = 1'b1;
            next_r.ph = PH_CYCLE;
            next_r.go = 1'b1;
          end else if (REQ_CMD == PEW_CMD_LOCK_WRITE) begin
            // prefix bytes are never kept as data, the page load carries on after them
            next_r.wr = 1'b1;
            next_r.ph = PH_PREFIX;
            next_r.go = 1'b1;
          end else begin
            next_r.wr = 1'b1;
            next_r.ph = PH_CYCLE;
            next_r.go = 1'b1;
          end
        end
      end
      PH_PREFIX: begin
        if (st_done) begin
          if (r.pre_idx == 2'd2) begin
            next_r.ph = PH_CYCLE;
            next_r.go = 1'b1;
          end else begin
            next_r.pre_idx = r.pre_idx + 2'd1;
            next_r.go = 1'b1;
          end
        end
      end
      PH_CYCLE: begin
        if (st_done) begin
          if (!r.wr) begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = st_rdata;
            next_r.ph = PH_IDLE;
          end else begin
            next_r.last_data = r.data;
            // shortened by the strobe tail and next-byte setup, so the device's own
            // window never lapses before the next falling write strobe
            next_r.win = 32'(LOAD_WIN - `PEW_TWPH_CYC - 4);
            next_r.ph = r.is_last ? PH_POLL : PH_LOAD;
            next_r.ready = !r.is_last;
            next_r.twc = 32'(TWC);
          end
        end
      end
      PH_LOAD: begin
        // a page write; the next byte must come inside the load window
        next_r.ready = 1'b1;
        if (r.win != 32'h0) begin
          next_r.win = r.win - 32'h1;
        end
        if (r.ready && REQ_VALID && REQ_CMD != PEW_CMD_READ
            && REQ_ADDR[12:6] == r.page) begin
          next_r.ready = 1'b0;
          next_r.addr = REQ_ADDR;
          next_r.data = REQ_DATA;
          next_r.is_last = REQ_LAST;
          next_r.ph = PH_CYCLE;
          next_r.go = 1'b1;
        end else if (r.win <= 32'h1) begin
          // window lost: device has started programming what it holds
          next_r.ready = 1'b0;
          next_r.ph = PH_POLL;
        end
      end
      PH_POLL: begin
        next_r.addr = {r.page, r.addr[5:0]};
        next_r.wr = 1'b0;
        next_r.ph = PH_POLLWAIT;
        next_r.go = 1'b1;
      end
      PH_POLLWAIT: begin
        if (r.twc != 32'h0) begin
          next_r.twc = r.twc - 32'h1;
        end
        if (st_done) begin
          // poll last byte: bit 7 true and bit 6 steady means done
          if (st_rdata[7] == r.last_data[7] && r.poll_rd
              && st_rdata[6] == r.rsp_data[6]) begin
            next_r.ph = PH_IDLE;
            next_r.poll_rd = 1'b0;
          end else if (r.twc == 32'h0) begin
            next_r.timeout = 1'b1;
            next_r.ph = PH_IDLE;
            next_r.poll_rd = 1'b0;
          end else begin
            next_r.poll_rd = 1'b1;
            next_r.rsp_data = st_rdata;
            next_r.ph = PH_POLL;
          end
        end
      end
      default: next_r.ph = PH_IDLE;
    endcase
    next_r.busy = (next_r.ph != PH_IDLE);
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // -----------------------------
  // pin cycle engine
  // -----------------------------
  // whole-cycle strobes are far wider than 15 ns, so glitches never arise
  pew_strobe u_strobe (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .go(r.go),
    .wr(r.wr),
    .addr(r.ph == PH_PREFIX ? pre_addr(r.pre_idx) : r.addr),
    .wdata(r.ph == PH_PREFIX ? pre_data(r.pre_idx) : r.data),
    .din_sync(dq_s2),
    .ce_n(EE_CE_N),
    .oe_n(EE_OE_N),
    .we_n(EE_WE_N),
    .a(EE_ADDR),
    .dout(EE_DQ_OUT),
    .doe(EE_DQ_OE),
    .done(st_done),
    .rdata(st_rdata)
  );
  assign REQ_READY = r.ready;
  assign RSP_VALID = r.rsp_valid;
  assign RSP_DATA = r.rsp_data;
  assign BUSY = r.busy;
  assign TIMEOUT = r.timeout;
endmodule
`default_nettype wire

/* bench/pew_host_assertions.sv */
// checker for the eeprom host controller's pin strobes and poll timeout
// assumes it is bound to pew_host and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module pew_host_assertions #(
  parameter int TWC = 1250000
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic BUSY,
  input wire logic TIMEOUT,
  input wire logic EE_CE_N,
  input wire logic EE_OE_N,
  input wire logic EE_WE_N,
  input wire pew_pkg::pew_addr_t EE_ADDR,
  input wire pew_pkg::pew_data_t EE_DQ_OUT,
  input wire logic EE_DQ_OE
);
  import pew_pkg::*;
  // ----------------------------------------
  // pin relations
  // ----------------------------------------
  int busy_cnt;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // counts whole busy spans, so a timeout can be tied to the programming bound
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      busy_cnt <= 0;
    else
      busy_cnt <= BUSY ? busy_cnt + 1 : 0;
  end
  read_strobe_a: assert property ($fell(EE_OE_N) |-> !EE_CE_N && EE_WE_N && !EE_DQ_OE)
    else $error("read strobe out of order");
  bus_free_a: assert property (EE_DQ_OE |-> EE_OE_N)
    else $error("data driven while device output on");
  write_strobe_a: assert property (!EE_WE_N |-> !EE_CE_N && EE_OE_N && EE_DQ_OE)
    else $error("write strobe without select or data");
  addr_hold_a: assert property (!EE_WE_N && !$past(EE_WE_N) |-> $stable(EE_ADDR))
    else $error("address moved during write pulse");
  data_hold_a: assert property ($rose(EE_WE_N) |-> !EE_CE_N && EE_DQ_OE && $stable(EE_DQ_OUT))
    else $error("data not held to write strobe rise");
  timeout_bound_a: assert property (TIMEOUT |-> busy_cnt >= TWC)
    else $error("timeout before programming bound");
  inhibit_a: assert property (!EE_OE_N |-> EE_WE_N)
    else $error("write strobe with output gate low");
  pulse_width_a: assert property ($fell(EE_WE_N) |-> !EE_WE_N [*8])
    else $error("write pulse too short");
endmodule
bind pew_host pew_host_assertions #(.TWC(TWC)) pew_host_assertions_inst (
  .CLK_SYS, .RST_N, .BUSY, .TIMEOUT, .EE_CE_N, .EE_OE_N, .EE_WE_N, .EE_ADDR, .EE_DQ_OUT,
  .EE_DQ_OE
);
`default_nettype wire

/* bench/pew_eeprom_model.sv */
// behavioural model of the 8k x 8 parallel eeprom on the host's pins
// assumes strobes like a static ram; all times in ns
`timescale 1ns/100ps
`default_nettype none
`include "pew_map.svh"
module pew_eeprom_model #(
  parameter int TWC_NS = 4000,
  parameter int LOAD_WIN_NS = 1600,
  parameter int ACC_NS = 60
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic [7:0] dq_out,
  input wire logic stuck,
  output logic [7:0] dq_in
);
  // ----------------------------------------
  // array, page latch and lock
  // ----------------------------------------
  logic [7:0] mem [8192];
  logic [7:0] pg [64];
  logic [12:0] sa [3];
  logic [7:0] sd [3];
  logic [63:0] ld;
  logic [12:0] la;
  logic [6:0] pa;
  logic [7:0] lastb, held;
  logic armed, loading, busy, tog, locked;
  int nb, seq;
  realtime t_fall, t_ld;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    sa = '{`PEW_LOCK_A0, `PEW_LOCK_A1, `PEW_LOCK_A2};
    sd = '{`PEW_LOCK_D0, `PEW_LOCK_D1, `PEW_LOCK_D2};
    {ld, armed, loading, busy, tog, locked, nb, seq} = '0;
  end
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n && oe_n && !busy) begin
      la = addr;
      t_fall = $realtime;
      armed = 1'b1;
    end
  always @(posedge we_n or posedge ce_n)
    if (armed && (we_n ^ ce_n)) begin
      armed = 1'b0;
      if ($realtime - t_fall >= 15) begin
        if (seq == nb && nb < 3 && la == sa[nb] && dq_out == sd[nb]) seq++;
        else begin
          pg[la[5:0]] = dq_out;
          ld[la[5:0]] = 1'b1;
          pa = la[12:6];
          lastb = dq_out;
        end
        nb++;
        loading = 1'b1;
        t_ld = $realtime;
      end
    end
  // a read ends the load at once: simpler than a device that keeps loading
  always @(negedge oe_n)
    if (!ce_n && we_n) begin
      tog = !tog;
      if (loading) t_ld = -1.0e6;
    end
  always begin
    #10;
    if (loading && $realtime - t_ld > LOAD_WIN_NS) begin
      if (seq == 3) locked = 1'b1;
      if (!locked || seq == 3) foreach (pg[i]) if (ld[i]) mem[{pa, 6'(i)}] = pg[i];
      {loading, nb, seq, ld} = '0;
      busy = 1'b1;
      #(TWC_NS);
      wait (!stuck);
      busy = 1'b0;
    end
  end
  always @(*) if (!ce_n && !oe_n) held = dq_in;
  // released lines show the inverse of the last value, never a kind constant
  assign #(ACC_NS) dq_in = (!ce_n && !oe_n && we_n) ?
    (busy ? {~lastb[7], tog, lastb[5:0]} : mem[addr]) : ~held;
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the eeprom host controller and its device model
// assumes the design package, map header and model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "pew_map.svh"
module tb;
  import pew_pkg::*;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic clk = 0;
  logic rst_n = 0;
  logic v = 0;
  logic lst = 0;
  logic stuck = 0;
  pew_cmd_e cmd = PEW_CMD_READ;
  pew_addr_t adr = '0;
  pew_addr_t ea;
  pew_data_t dat = '0;
  pew_data_t rsp, dqi, dqo;
  logic rdy, rv, busy, tmo, ce_n, oe_n, we_n, doe;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  always #4 clk = ~clk;
  // short timing counts keep the run brief
  pew_host #(.TWC(2000), .LOAD_WIN(200)) pew_host_inst (.CLK_SYS(clk), .RST_N(rst_n),
    .REQ_VALID(v), .REQ_CMD(cmd), .REQ_ADDR(adr), .REQ_DATA(dat), .REQ_LAST(lst),
    .REQ_READY(rdy), .RSP_VALID(rv), .RSP_DATA(rsp), .BUSY(busy), .TIMEOUT(tmo),
    .EE_CE_N(ce_n), .EE_OE_N(oe_n), .EE_WE_N(we_n), .EE_ADDR(ea), .EE_DQ_IN(dqi),
    .EE_DQ_OUT(dqo), .EE_DQ_OE(doe));
  pew_eeprom_model pew_eeprom_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(ea),
    .dq_out(dqo), .stuck(stuck), .dq_in(dqi));
  function automatic pew_data_t mem(pew_addr_t a);
    return pew_eeprom_model_inst.mem[a];
  endfunction
  task automatic summarize;
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic hung;
    err_total++;
    $display("unexpected wait: expected end, seen none");
    summarize;
  endtask
  // request held from just after an edge until the edge that takes it
  task automatic req(pew_cmd_e c, pew_addr_t a, pew_data_t d, logic l);
    // an edge passes first, so valid is never lowered and raised in one step
    tick(1);
    cmd = c;
    adr = a;
    dat = d;
    lst = l;
    v = 1'b1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    #1 v = 0;
    if (n == 3000) hung;
  endtask
  task automatic idle(output int c);
    tick(3);
    for (c = 0; c < 5000 && busy !== 1'b0; c++) tick(1);
    if (c == 5000) hung;
  endtask
  task automatic rd(pew_addr_t a, pew_data_t e);
    req(PEW_CMD_READ, a, 8'h00, 1'b0);
    for (n = 0; n < 100 && rv !== 1'b1; n++) tick(1);
    if (n == 100) hung;
    chk("read data", e, rsp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("idle strobes", 8'h07, {5'h00, ce_n, oe_n, we_n});
    chk("data enable", 8'h00, 8'(doe));
    chk("lock at delivery", 8'h00, 8'(pew_eeprom_model_inst.locked));
    $display("reset test ended");
  endtask
  task automatic t_byte;
    int c;
    req(PEW_CMD_WRITE, 13'h0123, 8'h5a, 1'b1);
    idle(c);
    chk("array byte", 8'h5a, mem(13'h0123));
    chk("polled to the end", 8'h01, 8'(c >= 500));
    rd(13'h0123, 8'h5a);
    $display("byte test ended");
  endtask
  task automatic t_page;
    int c;
    req(PEW_CMD_WRITE, 13'h0045, 8'h11, 1'b0);
    req(PEW_CMD_WRITE, 13'h0042, 8'h22, 1'b0);
    req(PEW_CMD_WRITE, 13'h0045, 8'h33, 1'b0);
    req(PEW_CMD_WRITE, 13'h007f, 8'h44, 1'b1);
    idle(c);
    chk("reloaded byte", 8'h33, mem(13'h0045));
    chk("second byte", 8'h22, mem(13'h0042));
    chk("page end byte", 8'h44, mem(13'h007f));
    chk("unloaded byte", 8'hff, mem(13'h0043));
    $display("page test ended");
  endtask
  task automatic t_lapse;
    int c;
    req(PEW_CMD_WRITE, 13'h0200, 8'h66, 1'b0);
    idle(c);
    chk("lapsed load", 8'h66, mem(13'h0200));
    $display("window test ended");
  endtask
  task automatic t_lock;
    int c;
    req(PEW_CMD_LOCK_WRITE, 13'h0300, 8'h77, 1'b1);
    idle(c);
    chk("lock on", 8'h01, 8'(pew_eeprom_model_inst.locked));
    chk("prefixed data", 8'h77, mem(13'h0300));
    chk("command byte", 8'hff, mem(`PEW_LOCK_A1));
    req(PEW_CMD_WRITE, 13'h0301, 8'h88, 1'b1);
    idle(c);
    chk("unprefixed data", 8'hff, mem(13'h0301));
    chk("timer ran", 8'h01, 8'(c >= 500));
    $display("lock test ended");
  endtask
  task automatic t_timeout;
    int c;
    stuck = 1;
    req(PEW_CMD_LOCK_WRITE, 13'h0400, 8'h99, 1'b1);
    for (n = 0; n < 3000 && tmo !== 1'b1; n++) tick(1);
    chk("poll timeout", 8'h01, 8'(tmo));
    stuck = 0;
    idle(c);
    $display("timeout test ended");
  endtask
  initial begin
    tick(3);
    rst_n = 1;
    tick(2);
    t_reset;
    t_byte;
    t_page;
    t_lapse;
    t_lock;
    t_timeout;
    summarize;
  end
endmodule
`default_nettype wire
